// ### rtl/pmode_pkg.sv
package pmode_pkg;

  // Processor modes held in the mode select field
  typedef enum logic [1:0] {
    MODE_SINGLE = 2'b00,
    MODE_EXPAND = 2'b01,
    MODE_BAD = 2'b10,
    MODE_MICRO = 2'b11
  } proc_mode_e;

  // Bit positions in the first mode register
  localparam int MODE_LSB = 0;
  localparam int STROBE_BIT = 2;
  localparam int MUX_LSB = 4;
  localparam int WIDTH1_BIT = 6;
  localparam int UPPER_LSB = 2;
  // Bit positions in the second mode register
  localparam int DBLK_BIT = 0;
  localparam int WIDTH2_BIT = 1;
  localparam int STICKY_BIT = 2;
  localparam int EXPAND_BIT = 3;
  localparam int GWAIT_BIT = 7;

  // Reset values of both mode registers (mode field loaded from strap)
  localparam logic [7:0] PM_FIRST_RST = 8'h00;
  localparam logic [7:0] PM_SECOND_RST = 8'h00;

  // Bus mux select encodings
  localparam logic [1:0] MUX_SEPARATE = 2'b00;
  localparam logic [1:0] MUX_ON_CS2 = 2'b01;
  localparam logic [1:0] MUX_ON_CS1 = 2'b10;
  localparam logic [1:0] MUX_ALL = 2'b11;

  // Address bus widths in lines
  localparam logic [4:0] ABUS_12 = 5'h0c;
  localparam logic [4:0] ABUS_16 = 5'h10;
  localparam logic [4:0] ABUS_20 = 5'h14;

  // Memory window bounds (20-bit addresses)
  localparam logic [19:0] IRAM_LO = 20'h0_0400;
  localparam logic [19:0] IRAM_HI = 20'h0_3fff;
  localparam logic [19:0] IROM_LO = 20'hd_0000;
  localparam logic [19:0] EXT_A_LO = 20'h0_4000;
  localparam logic [19:0] EXT_A_HI = 20'h0_7fff;
  localparam logic [19:0] EXT_B_LO = 20'h8_0000;
  localparam logic [19:0] EXT_B_HI = 20'hc_ffff;
  localparam logic [19:0] MUX_AREA_MASK = 20'h0_00ff;

  // Number of chip-select areas
  localparam int NUM_CS = 4;

  // Kinds of access presented by the core
  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_INT = 2'b01,
    ACC_EXT = 2'b10
  } acc_kind_e;

  // One access request from the core
  typedef struct packed {
    acc_kind_e kind;
    logic [1:0] cs_idx;
    logic [19:0] addr;
  } bus_req_s;

  // Register write strobe with data and byte select
  typedef struct packed {
    logic wr_first;
    logic wr_second;
    logic [7:0] data;
  } reg_wr_s;

endpackage : pmode_pkg

// ### rtl/bus_cycle_drv.sv
`timescale 1ns/1ps
module bus_cycle_drv
  import pmode_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Configuration
  input wire logic bus_on_i,
  input wire logic [3:0] cs_pin_en_i,
  input wire logic [19:0] addr_mask_i,
  // Access request
  input bus_req_s req_i,
  // Bus outputs
  output logic [19:0] addr_o,
  output logic [3:0] cs_n_o
);

  logic [19:0] addr;
  logic [19:0] next_addr;
  logic [3:0] cs_n;
  logic [3:0] next_cs_n;

  // Select line for one area, active low
  function automatic logic [3:0] cs_decode(input logic [1:0] idx, input logic [3:0] en);
    cs_decode = ~((4'h1 << idx) & en);
  endfunction : cs_decode

  //////////////////////////////////////////////////////////////////////
  // back-to-back outputs
  // Address only moves on an external access; internal and idle keep it
  always_comb begin
    next_addr = addr;
    next_cs_n = cs_n;
    if (!bus_on_i) begin
      next_cs_n = 4'hf;
    end else if (req_i.kind == ACC_EXT) begin
      next_addr = req_i.addr & addr_mask_i;
      next_cs_n = cs_decode(req_i.cs_idx, cs_pin_en_i);
    end else if (req_i.kind == ACC_INT) begin
      next_cs_n = 4'hf;
    end
  end

  // address cleared to zero by reset, then held until first external access
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      addr <= 20'h0_0000;
      cs_n <= 4'hf;
    end else begin
      addr <= next_addr;
      cs_n <= next_cs_n;
    end
  end

  assign addr_o = addr;
  assign cs_n_o = cs_n;

  // Internal access keeps address, releases select
  a_int_keeps_addr: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (req_i.kind == ACC_INT) |=> ($stable(addr_o) && cs_n_o == 4'hf))
    else $error("internal access moved address");
  // Idle leaves both untouched
  a_idle_stable: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (req_i.kind == ACC_IDLE && bus_on_i) |=> ($stable(addr_o) && $stable(cs_n_o)))
    else $error("idle cycle changed bus");

endmodule : bus_cycle_drv

// ### rtl/proc_mode_ctrl.sv
// Contract
// - Hardware reset: strap low gives single-chip, strap high gives microprocessor.
// - Mode field 00 single-chip, 01 expansion, 11 microprocessor, 10 forbidden.
// - Writing mode field sets that mode regardless of strap level.
// - Reset with strap high blocks internal ROM until next hardware reset.
// - Mode register writes ignored unless protect unlock bit is set.
// - Mode field survives software and watchdog resets.
// - Expansion with all-mux: 8-bit bus, ports freed, 256-byte areas.
// - Sticky bit sets on write of one; zero writes ignored.
// - Global wait adds one wait; select wait-disable zero forces wait.
// - Expand bit chooses internal windows versus extra external ranges.
// - Flash rewrite mode forces expand and data block bits to one.
// - Expansion or microprocessor mode turns pins into bus pins.
// - Mux field chooses separate or multiplexed bus.
// - Mux bus shares D0-D7 with A1-A8; only even addresses reachable.
// - Two width bits give 12, 16 or 20 address lines.
// - After leaving single-chip, address undefined until first external access.
// - Sixteen data lines; width strap held constant while running.
// - Each chip-select pin is select output or port per enable bit.
// - Area change moves address and select; internal only select; idle neither.
// - Mux field 00 separate, 01 mux on CS2, 10 mux on CS1.
// - Strobe style bit chooses write-plus-upper-enable or split lane strobes; split strobes only with width strap low.
`timescale 1ns/1ps
module proc_mode_ctrl
  import pmode_pkg::*;
(
  // Clock and resets
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic soft_rst_i,
  // Straps and flash state
  input wire logic mode_strap_pin_i,
  input wire logic byte_strap_pin_i,
  input wire logic cpu_rewrite_mode_bit_i,
  // Register writes from the core
  input reg_wr_s reg_wr_i,
  input wire logic mode_reg_write_unlock_i,
  input wire logic [3:0] select_wait_disable_bit_i,
  input wire logic [3:0] cs_pin_en_i,
  // Access request and write lanes
  input bus_req_s req_i,
  input wire logic wr_lo_i,
  input wire logic wr_hi_i,
  input wire logic rd_i,
  // Register readback and mode state
  output logic [7:0] processor_mode_reg_first_o,
  output logic [7:0] processor_mode_reg_second_o,
  output proc_mode_e mode_o,
  output logic rom_blocked_o,
  // Bus configuration
  output logic bus_pins_on_o,
  output logic mux_active_o,
  output logic [4:0] addr_width_o,
  output logic ports_freed_o,
  output logic wait_insert_o,
  output logic access_denied_o,
  // Bus pins
  output logic [19:0] addr_o,
  output logic [3:0] cs_n_o,
  output logic rd_n_o,
  output logic low_lane_store_n_o,
  output logic high_lane_store_n_o,
  output logic upper_lane_enable_n_o
);

  logic [7:0] pm_first, next_pm_first;
  logic [7:0] pm_second, next_pm_second;
  logic rom_blk, next_rom_blk;
  logic taken, next_taken;
  logic strap_s1, strap_s2, byte_s1, byte_s2;
  logic [1:0] settle;

  //////////////////////////////////////////////////////////////////////
  // Strap synchronisers; settle holds off the mode load until stage two is valid
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      strap_s1 <= 1'b0;
      strap_s2 <= 1'b0;
      byte_s1 <= 1'b0;
      byte_s2 <= 1'b0;
      settle <= 2'b00;
    end else begin
      strap_s1 <= mode_strap_pin_i;
      strap_s2 <= strap_s1;
      byte_s1 <= byte_strap_pin_i;
      byte_s2 <= byte_s1;
      settle <= {settle[0], 1'b1};
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Mode register next values
  always_comb begin
    next_pm_first = pm_first;
    next_pm_second = pm_second;
    next_rom_blk = rom_blk;
    next_taken = taken;
    if (!taken) begin
      // strap taken once both sync stages hold it
      next_taken = settle[1];
      next_pm_first[MODE_LSB +: 2] = (settle[1] && strap_s2) ? MODE_MICRO : MODE_SINGLE;
      next_rom_blk = settle[1] && strap_s2;
    end else begin
      // soft reset spares the mode field
      if (soft_rst_i) begin
        next_pm_first = {PM_FIRST_RST[7:2], pm_first[MODE_LSB +: 2]};
        next_pm_second = PM_SECOND_RST;
      end else if (mode_reg_write_unlock_i) begin
        if (reg_wr_i.wr_first) begin
          next_pm_first = reg_wr_i.data;
          if (reg_wr_i.data[MODE_LSB +: 2] == MODE_BAD) begin
            next_pm_first[MODE_LSB +: 2] = pm_first[MODE_LSB +: 2];
          end
        end
        if (reg_wr_i.wr_second) begin
          next_pm_second = reg_wr_i.data;
          next_pm_second[STICKY_BIT] = pm_second[STICKY_BIT] | reg_wr_i.data[STICKY_BIT];
        end
      end
      if (cpu_rewrite_mode_bit_i) begin
        next_pm_second[EXPAND_BIT] = 1'b1;
        next_pm_second[DBLK_BIT] = 1'b1;
      end
    end
  end
  // Registers; hardware reset only from rst_b_i
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pm_first <= PM_FIRST_RST;
      pm_second <= PM_SECOND_RST;
      rom_blk <= 1'b0;
      taken <= 1'b0;
    end else begin
      pm_first <= next_pm_first;
      pm_second <= next_pm_second;
      rom_blk <= next_rom_blk;
      taken <= next_taken;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Configuration decode
  logic [1:0] mux_sel;
  logic exp_mode, cs_mux, in_iram, in_irom, in_ext_a, in_ext_b, wait_cs;
  logic [19:0] addr_mask;
  acc_kind_e drv_kind;
  // Inclusive range check
  function automatic logic in_range(input logic [19:0] a, lo, hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  assign mux_sel = pm_first[MUX_LSB +: 2];
  // bus pins in both external modes
  assign exp_mode = (pm_first[MODE_LSB +: 2] == MODE_EXPAND) ||
                    (pm_first[MODE_LSB +: 2] == MODE_MICRO);

  always_comb begin
    cs_mux = 1'b0;
    if (mux_sel == MUX_ALL) begin
      cs_mux = 1'b1;
    end else if (mux_sel == MUX_ON_CS2) begin
      cs_mux = (req_i.cs_idx == 2'd2);
    end else if (mux_sel == MUX_ON_CS1) begin
      cs_mux = (req_i.cs_idx == 2'd1);
    end
  end

  always_comb begin
    addr_width_o = ABUS_20;
    addr_mask = 20'hf_ffff;
    if (pm_first[WIDTH1_BIT] && pm_second[WIDTH2_BIT]) begin
      addr_width_o = ABUS_12;
      addr_mask = 20'h0_0fff;
    end else if (pm_first[WIDTH1_BIT]) begin
      addr_width_o = ABUS_16;
      addr_mask = 20'h0_ffff;
    end
    // all-mux expansion shrinks areas to 256 bytes
    if (ports_freed_o) begin
      addr_mask = MUX_AREA_MASK;
    end
  end
  // ports freed only in expansion with all-mux
  assign ports_freed_o = (pm_first[MODE_LSB +: 2] == MODE_EXPAND) && (mux_sel == MUX_ALL);
  assign mux_active_o = exp_mode && cs_mux && (req_i.kind == ACC_EXT);

  assign in_iram = in_range(req_i.addr, IRAM_LO, IRAM_HI);
  assign in_irom = (req_i.addr >= IROM_LO);
  assign in_ext_a = in_range(req_i.addr, EXT_A_LO, EXT_A_HI);
  assign in_ext_b = in_range(req_i.addr, EXT_B_LO, EXT_B_HI);

  // Refused: ROM when blocked, reserved windows, odd mux addresses
  always_comb begin
    access_denied_o = 1'b0;
    if (req_i.kind == ACC_INT && in_irom && (rom_blk ||
        pm_first[MODE_LSB +: 2] == MODE_MICRO)) begin
      access_denied_o = 1'b1;
    end else if (req_i.kind == ACC_EXT && pm_second[EXPAND_BIT] && (in_ext_a || in_ext_b)) begin
      access_denied_o = 1'b1;
    end else if (req_i.kind == ACC_INT && !pm_second[EXPAND_BIT] && !in_iram && !in_irom &&
                 req_i.addr >= IRAM_LO) begin
      access_denied_o = 1'b1;
    // odd address unreachable on mux bus
    end else if (mux_active_o && req_i.addr[0]) begin
      access_denied_o = 1'b1;
    end else if (req_i.kind == ACC_EXT && !exp_mode) begin
      access_denied_o = 1'b1;
    end
  end
  // wait state from global bit or area bit
  assign wait_cs = (req_i.kind == ACC_EXT) && !select_wait_disable_bit_i[req_i.cs_idx];
  assign wait_insert_o = (req_i.kind != ACC_IDLE) && (pm_second[GWAIT_BIT] || wait_cs);

  //////////////////////////////////////////////////////////////////////
  // Strobes; style bit picks lane strobes with width strap low, else write plus upper enable
  logic rd_n, lo_n, hi_n, ube_n;
  logic next_rd_n, next_lo_n, next_hi_n, next_ube_n;
  logic ext_go;

  assign ext_go = exp_mode && req_i.kind == ACC_EXT && !access_denied_o;

  always_comb begin
    next_rd_n = 1'b1;
    next_lo_n = 1'b1;
    next_hi_n = 1'b1;
    next_ube_n = 1'b1;
    if (ext_go) begin
      next_rd_n = !rd_i;
      if (pm_first[STROBE_BIT] && !byte_s2) begin
        next_lo_n = !wr_lo_i;
        next_hi_n = !wr_hi_i;
      end else begin
        next_lo_n = !(wr_lo_i || wr_hi_i);
        // upper lane unused on mux bus
        next_ube_n = !(wr_hi_i || (rd_i && !cs_mux)) || cs_mux;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_n <= 1'b1;
      lo_n <= 1'b1;
      hi_n <= 1'b1;
      ube_n <= 1'b1;
    end else begin
      rd_n <= next_rd_n;
      lo_n <= next_lo_n;
      hi_n <= next_hi_n;
      ube_n <= next_ube_n;
    end
  end

  // Refused requests reach the driver as idle, so address and select hold
  assign drv_kind = ext_go ? ACC_EXT :
                    ((req_i.kind == ACC_INT && !access_denied_o) ? ACC_INT : ACC_IDLE);
  // Address and chip selects; pin enables gate each select
  bus_cycle_drv u_drv (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .bus_on_i(exp_mode),
    .cs_pin_en_i(cs_pin_en_i),
    .addr_mask_i(addr_mask),
    .req_i({drv_kind, req_i.cs_idx, req_i.addr}),
    .addr_o(addr_o),
    .cs_n_o(cs_n_o)
  );

  assign rd_n_o = rd_n;
  assign low_lane_store_n_o = lo_n;
  assign high_lane_store_n_o = hi_n;
  assign upper_lane_enable_n_o = ube_n;
  assign processor_mode_reg_first_o = pm_first;
  assign processor_mode_reg_second_o = pm_second;
  assign mode_o = proc_mode_e'(pm_first[MODE_LSB +: 2]);
  assign rom_blocked_o = rom_blk;
  assign bus_pins_on_o = exp_mode;

  //////////////////////////////////////////////////////////////////////
  // Checks
  a_locked_write: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (taken && !mode_reg_write_unlock_i && !soft_rst_i && !cpu_rewrite_mode_bit_i)
    |=> $stable(pm_first) && $stable(pm_second))
    else $error("locked mode register changed");
  a_mode_written: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (taken && mode_reg_write_unlock_i && reg_wr_i.wr_first && !soft_rst_i &&
     reg_wr_i.data[1:0] != MODE_BAD) |=> mode_o == $past(reg_wr_i.data[1:0]))
    else $error("mode write not applied");
  a_no_bad_mode: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    mode_o != MODE_BAD)
    else $error("forbidden mode held");
  a_soft_keeps: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (taken && soft_rst_i) |=> $stable(mode_o))
    else $error("soft reset changed mode");
  a_sticky_hold: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (pm_second[STICKY_BIT] && !soft_rst_i) |=> pm_second[STICKY_BIT])
    else $error("sticky bit cleared");
  a_rewrite_force: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (taken && cpu_rewrite_mode_bit_i) |=> pm_second[EXPAND_BIT] && pm_second[DBLK_BIT])
    else $error("rewrite mode did not force bits");
  a_rom_blocked: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (rom_blk && req_i.kind == ACC_INT && req_i.addr >= IROM_LO) |-> access_denied_o)
    else $error("ROM reached while blocked");
  a_strap_mode: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (!taken && settle[1]) |=> mode_o == ($past(strap_s2) ? MODE_MICRO : MODE_SINGLE) &&
    rom_blk == $past(strap_s2))
    else $error("reset mode does not follow strap");
  a_wait_area: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    wait_cs |-> wait_insert_o)
    else $error("area without wait-disable got no wait");
  a_mux_even: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (mux_active_o && req_i.addr[0]) |=> $stable(cs_n_o) || cs_n_o == 4'hf)
    else $error("odd mux address reached");
  c_micro_entry: cover property (@(posedge core_clk_i) disable iff (!rst_b_i)
    mode_o == MODE_SINGLE ##1 mode_o == MODE_MICRO);
  c_ext_access: cover property (@(posedge core_clk_i) disable iff (!rst_b_i) ext_go);
  c_mux_access: cover property (@(posedge core_clk_i) disable iff (!rst_b_i) mux_active_o);
  c_ports_freed: cover property (@(posedge core_clk_i) disable iff (!rst_b_i) ports_freed_o);

endmodule : proc_mode_ctrl

// ### verif/ext_dev.sv
`timescale 1ns/1ps
module ext_dev (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Strap level wanted for the next run
  input wire logic byte_cfg_i,
  // Bus pins seen from the device side
  input wire logic [19:0] addr_i,
  input wire logic [3:0] cs_n_i,
  input wire logic rd_n_i,
  // Strap and observed cycle
  output logic byte_strap_pin_o,
  output logic [19:0] last_rd_o
);
  ////////////////////////////////////////////////////////////////////////////////
  // Width strap taken only while reset is low, never moved while running
  // strap held constant
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      byte_strap_pin_o <= byte_cfg_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Address of the last selected read; unselected cycles are ignored
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      last_rd_o <= 20'h0_0000;
    end else if (!rd_n_i && cs_n_i != 4'hf) begin
      last_rd_o <= addr_i;
    end
  end
endmodule : ext_dev

// ### verif/proc_mode_ctrl_tb.sv
`timescale 1ns/1ps
module proc_mode_ctrl_tb;
  import pmode_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_b_i, soft_rst_i, strap, byte_cfg, byte_pin, rewrite, rd_i, unlock;
  reg_wr_s reg_wr_i;
  bus_req_s req_i;
  logic [3:0] wdis, cs_en, cs_n;
  logic [7:0] pm_a, pm_b;
  proc_mode_e mode;
  logic rom_blk, pins_on, mux_on, ports_fr, wait_o, denied, rd_n;
  logic wr_lo, wr_hi, lo_n, hi_n, ube_n;
  logic [4:0] awid;
  logic [19:0] addr, ext_last;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;

  proc_mode_ctrl proc_mode_ctrl_i (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .soft_rst_i(soft_rst_i),
    .mode_strap_pin_i(strap), .byte_strap_pin_i(byte_pin),
    .cpu_rewrite_mode_bit_i(rewrite), .reg_wr_i(reg_wr_i),
    .mode_reg_write_unlock_i(unlock), .select_wait_disable_bit_i(wdis),
    .cs_pin_en_i(cs_en), .req_i(req_i), .wr_lo_i(wr_lo), .wr_hi_i(wr_hi), .rd_i(rd_i),
    .processor_mode_reg_first_o(pm_a), .processor_mode_reg_second_o(pm_b),
    .mode_o(mode), .rom_blocked_o(rom_blk), .bus_pins_on_o(pins_on),
    .mux_active_o(mux_on), .addr_width_o(awid), .ports_freed_o(ports_fr),
    .wait_insert_o(wait_o), .access_denied_o(denied), .addr_o(addr), .cs_n_o(cs_n),
    .rd_n_o(rd_n), .low_lane_store_n_o(lo_n), .high_lane_store_n_o(hi_n),
    .upper_lane_enable_n_o(ube_n)
  );

  ext_dev ext_dev_i (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .byte_cfg_i(byte_cfg),
    .addr_i(addr), .cs_n_i(cs_n), .rd_n_i(rd_n),
    .byte_strap_pin_o(byte_pin), .last_rd_o(ext_last)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard; a whole run needs well under 600 cycles
  always #10 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      summarize();
    end
  end

  task automatic summarize;
    $display("checks=%0d fails=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tick;
    @(posedge core_clk_i);
    #2;
  endtask : tick

  // Strobe held one edge, then a quiet edge so strobes never re-assert in one step
  task automatic wr(input logic sec, input logic [7:0] d);
    reg_wr_i = '{wr_first: !sec, wr_second: sec, data: d};
    tick();
    reg_wr_i = '0;
    tick();
  endtask : wr

  // Request applied; combinational answers settle after 1 ns, caller ticks
  task automatic go(input acc_kind_e k, input logic [1:0] c, input logic [19:0] a);
    req_i = '{kind: k, cs_idx: c, addr: a};
    rd_i = (k == ACC_EXT);
    #1;
  endtask : go

  task automatic hw(input logic s, input logic b);
    rst_b_i = 1'b0;
    strap = s;
    byte_cfg = b;
    repeat (12) tick();
    rst_b_i = 1'b1;
    repeat (4) tick();
  endtask : hw

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    soft_rst_i = 1'b0;
    rewrite = 1'b0;
    unlock = 1'b0;
    wdis = 4'hf;
    cs_en = 4'hf;
    reg_wr_i = '0;
    req_i = '0;
    rd_i = 1'b0;
    wr_lo = 1'b0;
    wr_hi = 1'b0;
    hw(1'b0, 1'b0);
    chk(mode, MODE_SINGLE);
    chk(pm_a, 8'h00);
    chk(rom_blk, 1'b0);
    wr(1'b0, 8'h01);
    chk(pm_a, 8'h00);
    unlock = 1'b1;
    $display("test reset_lock done");
    wr(1'b0, 8'h01);
    chk(mode, MODE_EXPAND);
    chk(pins_on, 1'b1);
    wr(1'b0, 8'h02);
    chk(pm_a, 8'h01);
    wr(1'b0, 8'h03); // entry issued from outside internal ROM
    chk(mode, MODE_MICRO);
    // Upper-lane write in write-plus-enable style
    go(ACC_EXT, 2'd1, 20'h0_0100);
    rd_i = 1'b0;
    wr_hi = 1'b1;
    tick();
    chk(ube_n, 1'b0);
    chk(lo_n, 1'b0);
    wr_hi = 1'b0;
    go(ACC_IDLE, 2'd0, 20'h0_0000);
    wr(1'b0, 8'h00); // exit issued from outside internal ROM
    chk(pins_on, 1'b0);
    wr(1'b0, 8'h04); // style bit changed while mode is single-chip
    wr(1'b0, 8'h07);
    // Same write in split lane style
    go(ACC_EXT, 2'd1, 20'h0_0100);
    rd_i = 1'b0;
    wr_hi = 1'b1;
    tick();
    chk(hi_n, 1'b0);
    chk(lo_n, 1'b1);
    chk(ube_n, 1'b1);
    wr_hi = 1'b0;
    go(ACC_IDLE, 2'd0, 20'h0_0000);
    $display("test modes done");
    wr(1'b0, 8'h40);
    chk(awid, ABUS_16);
    wr(1'b1, 8'h02);
    chk(awid, ABUS_12);
    wr(1'b1, 8'h00);
    wr(1'b0, 8'h00);
    chk(awid, ABUS_20);
    $display("test width done");
    wr(1'b1, 8'h04);
    wr(1'b1, 8'h00);
    chk(pm_b, 8'h04);
    wr(1'b0, 8'h01);
    soft_rst_i = 1'b1;
    tick();
    soft_rst_i = 1'b0;
    tick();
    chk(pm_a, 8'h01);
    chk(pm_b, 8'h00);
    $display("test sticky_soft done");
    go(ACC_EXT, 2'd0, 20'h1_0000);
    chk(wait_o, 1'b0);
    wdis = 4'he;
    #1;
    chk(wait_o, 1'b1);
    wdis = 4'hf;
    wr(1'b1, 8'h80);
    go(ACC_INT, 2'd0, 20'h0_0500);
    chk(wait_o, 1'b1);
    wr(1'b1, 8'h00);
    $display("test wait done");
    go(ACC_EXT, 2'd1, 20'h0_0100);
    tick();
    chk(cs_n, 4'hd);
    chk(addr, 20'h0_0100);
    go(ACC_EXT, 2'd1, 20'h0_0200);
    tick();
    chk(cs_n, 4'hd);
    chk(addr, 20'h0_0200);
    go(ACC_INT, 2'd0, 20'h0_0500);
    tick();
    chk(cs_n, 4'hf);
    chk(addr, 20'h0_0200);
    go(ACC_EXT, 2'd2, 20'h0_0300);
    tick();
    go(ACC_IDLE, 2'd0, 20'h0_0000);
    tick();
    chk(cs_n, 4'hb);
    chk(addr, 20'h0_0300);
    chk(ext_last, 20'h0_0300);
    cs_en = 4'hb;
    go(ACC_EXT, 2'd2, 20'h0_0400);
    tick();
    chk(cs_n, 4'hf);
    cs_en = 4'hf;
    $display("test bus_cycles done");
    go(ACC_EXT, 2'd0, EXT_A_LO);
    chk(denied, 1'b0);
    wr(1'b1, 8'h08);
    chk(denied, 1'b1);
    wr(1'b1, 8'h00);
    rewrite = 1'b1;
    tick();
    tick();
    chk(pm_b, 8'h09);
    chk(denied, 1'b1);
    rewrite = 1'b0;
    tick();
    $display("test expand done");
    wdis = 4'h0; // mux areas keep their wait state
    wr(1'b0, 8'h10);
    wr(1'b0, 8'h11); // mode written apart from upper bits
    go(ACC_EXT, 2'd2, 20'h1_0000);
    chk(mux_on, 1'b1);
    go(ACC_EXT, 2'd1, 20'h1_0000);
    chk(mux_on, 1'b0);
    wr(1'b0, 8'h20);
    wr(1'b0, 8'h21);
    chk(mux_on, 1'b1);
    go(ACC_IDLE, 2'd0, 20'h0_0000);
    $display("test mux done");
    hw(1'b0, 1'b1);
    wr(1'b0, 8'h30);
    wr(1'b0, 8'h31); // mode written apart from upper bits
    chk(ports_fr, 1'b1);
    go(ACC_EXT, 2'd0, 20'h1_2345);
    chk(denied, 1'b1);
    go(ACC_EXT, 2'd0, 20'h1_2346);
    tick();
    chk(addr, 20'h1_2346 & MUX_AREA_MASK);
    go(ACC_IDLE, 2'd0, 20'h0_0000);
    wdis = 4'hf;
    $display("test ports_freed done");
    hw(1'b1, 1'b0); // all-mux never written below with strap high
    chk(mode, MODE_MICRO);
    chk(pm_a, 8'h03);
    chk(rom_blk, 1'b1);
    go(ACC_INT, 2'd0, IROM_LO);
    chk(denied, 1'b1);
    wr(1'b0, 8'h00);
    chk(mode, MODE_SINGLE);
    chk(denied, 1'b1);
    $display("test strap_high done");
    summarize();
  end
endmodule : proc_mode_ctrl_tb
